//--- rtl/cfe_encoder.sv
// forward-channel encoder: apb registers, framer and bit sequencer
`timescale 1ns/1ps
`default_nettype none
module cfe_encoder #(
	parameter int MSG_DEPTH = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	output logic signed [12:0] mod_level,
	output logic               output_route_select,
	output logic      [15:0]   data_rate,
	output logic               sat_enable,
	output logic               tx_active
);
	localparam int IDX_W = $clog2(MSG_DEPTH);

	// address match used by every register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	// append the 12-bit cyclic parity to a 28-bit word
	function automatic logic [39:0] bch_word(input logic [27:0] d);
		logic [11:0] r;
		logic        fb;
		r = 12'h000;
		for (int i = 27; i >= 0; i--) begin
			fb = d[i] ^ r[11];
			r  = {r[10:0], 1'b0} ^ (fb ? cfe_pkg::BCH_POLY : 12'h000);
		end
		return {d, r};
	endfunction : bch_word

	// words per frame of each stream kind
	function automatic logic [3:0] reps_of(input cfe_pkg::cfe_kind_e k);
		case (k)
			cfe_pkg::K_FILL, cfe_pkg::K_CMSG: return cfe_pkg::CTRL_REPS;
			cfe_pkg::K_WB:                    return cfe_pkg::WB_REPS;
			default:                          return 4'h1;
		endcase
	endfunction : reps_of

	cfe_line_if lif ();

	logic [cfe_pkg::CTRL_W-1:0] ctrl_ff;
	logic [15:0]                rate_ff;
	logic [11:0]                level_ff;
	logic [7:0]                 bursts_ff;
	logic [7:0]                 bi_delay_ff;
	logic [27:0]                fill_a_ff;
	logic [27:0]                fill_b_ff;
	logic [27:0]                voice_msg_ff;
	logic [23:0]                dsat_ff;
	logic [27:0]                msg_a_ff [MSG_DEPTH];
	logic [27:0]                msg_b_ff [MSG_DEPTH];
	logic [3:0]                 msg_lines_ff;
	logic [31:0]                prdata_ff;
	logic                       pslverr_ff;
	logic                       dsat_on_ff;

	cfe_pkg::cfe_state_e st_ff;
	cfe_pkg::cfe_state_e nxt_st;
	cfe_pkg::cfe_kind_e  kind_ff;
	cfe_pkg::cfe_kind_e  nxt_kind;
	logic [6:0]          left_ff;
	logic [6:0]          nxt_left;
	logic [3:0]          rep_ff;
	logic [3:0]          nxt_rep;
	logic [IDX_W-1:0]    line_ff;
	logic [IDX_W-1:0]    nxt_line;
	logic [7:0]          burst_ff;
	logic [7:0]          nxt_burst;
	logic [39:0]         sh_ff;
	logic                out_bit_ff;
	logic                out_valid_ff;
	logic [3:0]          bi_cnt_ff;
	logic                bi_trig_ff;
	logic [7:0]          bi_dly_ff;
	logic                bi_busy_ff;
	logic                launch;
	logic                load_word;
	logic                load_sync;

	// bus decode
	wire setup_ph  = psel && !penable;
	wire wr_en     = psel && penable && pwrite;
	wire sel_ctrl  = hit(paddr, cfe_pkg::OFS_CTRL);
	wire sel_rate  = hit(paddr, cfe_pkg::OFS_RATE);
	wire sel_lvl   = hit(paddr, cfe_pkg::OFS_LEVEL);
	wire sel_bur   = hit(paddr, cfe_pkg::OFS_BURSTS);
	wire sel_bid   = hit(paddr, cfe_pkg::OFS_BI_DELAY);
	wire sel_fa    = hit(paddr, cfe_pkg::OFS_FILL_A);
	wire sel_fb    = hit(paddr, cfe_pkg::OFS_FILL_B);
	wire sel_vm    = hit(paddr, cfe_pkg::OFS_VOICE_MSG);
	wire sel_dsat  = hit(paddr, cfe_pkg::OFS_DSAT);
	wire sel_mwr   = hit(paddr, cfe_pkg::OFS_MSG_WR);
	wire sel_mln   = hit(paddr, cfe_pkg::OFS_MSG_LINES);
	wire sel_cmd   = hit(paddr, cfe_pkg::OFS_CMD);
	wire sel_stat  = hit(paddr, cfe_pkg::OFS_STATUS);
	wire sel_any   = sel_ctrl | sel_rate | sel_lvl | sel_bur | sel_bid | sel_fa | sel_fb
	               | sel_vm | sel_dsat | sel_mwr | sel_mln | sel_cmd | sel_stat;

	// command pulses
	wire wr_cmd     = wr_en && sel_cmd;
	wire cmd_send   = wr_cmd && pwdata[cfe_pkg::CMD_SEND_BIT];
	wire cmd_stop   = wr_cmd && pwdata[cfe_pkg::CMD_STOP_BIT];
	wire cmd_fsend  = wr_cmd && pwdata[cfe_pkg::CMD_FILL_SEND_BIT];
	wire cmd_fstop  = wr_cmd && pwdata[cfe_pkg::CMD_FILL_STOP_BIT];
	wire supervisory_pattern_send_cmd = wr_cmd && pwdata[cfe_pkg::CMD_DSAT_SEND_BIT];
	wire supervisory_pattern_stop_cmd = wr_cmd && pwdata[cfe_pkg::CMD_DSAT_STOP_BIT];
	wire halt_ctrl  = wr_en && (sel_ctrl || sel_fa || sel_fb || sel_rate);

	// control fields
	wire chan_voice  = ctrl_ff[cfe_pkg::CTRL_CHAN_BIT];
	wire narrow      = ctrl_ff[cfe_pkg::CTRL_NARROW_BIT];
	wire voice_payload_choice = ctrl_ff[cfe_pkg::CTRL_PAYLOAD_BIT];
	wire [1:0] mode  = ctrl_ff[cfe_pkg::CTRL_MODE_LSB +: 2];
	wire [1:0] bi_op = ctrl_ff[cfe_pkg::CTRL_BI_LSB +: 2];
	wire sync_delay_option      = (bi_op == cfe_pkg::BI_SYNC_DLY);
	wire first_bit_delay_option = (bi_op == cfe_pkg::BI_FIRST_DLY);

	// kind classification
	wire is_ctrl  = (kind_ff == cfe_pkg::K_FILL) || (kind_ff == cfe_pkg::K_CMSG);
	wire is_msg   = (kind_ff == cfe_pkg::K_CMSG) || (kind_ff == cfe_pkg::K_WB)
	              || (kind_ff == cfe_pkg::K_NB) || (kind_ff == cfe_pkg::K_DST);
	wire dsat_ok  = dsat_on_ff && chan_voice && narrow;
	wire [3:0] lines_eff = (msg_lines_ff > 4'(MSG_DEPTH)) ? 4'(MSG_DEPTH) : msg_lines_ff;

	// send picks framing from channel and bandwidth
	wire cfe_pkg::cfe_kind_e send_kind = !chan_voice ?
		((lines_eff != 4'h0) ? cfe_pkg::K_CMSG : cfe_pkg::K_FILL) :
		(!narrow ? cfe_pkg::K_WB :
		(voice_payload_choice ? cfe_pkg::K_DST : cfe_pkg::K_NB));
	wire cfe_pkg::cfe_kind_e done_kind = !chan_voice ? cfe_pkg::K_FILL :
		(dsat_ok ? cfe_pkg::K_DSAT : cfe_pkg::K_NONE);
	wire cfe_pkg::cfe_kind_e stop_kind = dsat_ok ? cfe_pkg::K_DSAT : cfe_pkg::K_NONE;

	// bit timing
	wire bi_slot = is_ctrl && (bi_cnt_ff == cfe_pkg::BI_SPACING);
	wire adv     = lif.tick && (st_ff != cfe_pkg::ST_IDLE) && !bi_slot;
	wire seg_end = adv && (left_ff == 7'h01);
	// dotting opens with a one: control dotting is corrected for its length, wideband relies on odd lengths
	wire dot_bit = left_ff[0] ^ (is_ctrl && !cfe_pkg::DOT_CTRL[0]);

	// busy/idle bit value
	wire bi_val = (bi_op == cfe_pkg::BI_IDLE) ? 1'b1 :
		(bi_op == cfe_pkg::BI_BUSY) ? 1'b0 : !bi_busy_ff;

	// word selection for the next load
	wire [27:0] msg_a_sel = msg_a_ff[nxt_line];
	wire [27:0] msg_b_sel = msg_b_ff[nxt_line];
	wire [27:0] fill_sel  = nxt_rep[0] ? fill_b_ff : fill_a_ff;
	wire [27:0] cmsg_sel  = nxt_rep[0] ? msg_b_sel : msg_a_sel;
	wire [27:0] data_sel  = (nxt_kind == cfe_pkg::K_FILL) ? fill_sel :
		(nxt_kind == cfe_pkg::K_CMSG) ? cmsg_sel : voice_msg_ff;
	wire [39:0] enc_word  = bch_word(data_sel);
	wire [39:0] load_val  = (nxt_kind == cfe_pkg::K_DST) ? {~dsat_ff, 16'h0000} :
		(nxt_kind == cfe_pkg::K_DSAT) ? {dsat_ff, 16'h0000} : enc_word;

	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff      <= cfe_pkg::RST_CTRL;
			rate_ff      <= cfe_pkg::RST_RATE;
			level_ff     <= cfe_pkg::RST_LEVEL;
			bursts_ff    <= cfe_pkg::RST_BURSTS;
			bi_delay_ff  <= cfe_pkg::RST_BI_DELAY;
			fill_a_ff    <= 28'h0000000;
			fill_b_ff    <= 28'h0000000;
			voice_msg_ff <= 28'h0000000;
			dsat_ff      <= cfe_pkg::RST_DSAT;
			msg_lines_ff <= 4'h0;
		end else if (wr_en) begin
			if (sel_ctrl) ctrl_ff <= pwdata[cfe_pkg::CTRL_W-1:0];
			if (sel_rate) rate_ff <= pwdata[15:0];
			if (sel_lvl) level_ff <= pwdata[11:0];
			if (sel_bur) bursts_ff <= pwdata[7:0];
			if (sel_bid) bi_delay_ff <= pwdata[7:0];
			if (sel_fa) fill_a_ff <= pwdata[27:0];
			if (sel_fb) fill_b_ff <= pwdata[27:0];
			if (sel_vm) voice_msg_ff <= pwdata[27:0];
			if (sel_dsat) dsat_ff <= pwdata[23:0];
			if (sel_mln) msg_lines_ff <= pwdata[3:0];
		end
	end

	// message line storage, no reset needed
	always_ff @(posedge pclk) begin
		if (wr_en && sel_mwr && !pwdata[cfe_pkg::MSG_STREAM_BIT]) begin
			msg_a_ff[pwdata[cfe_pkg::MSG_IDX_LSB +: IDX_W]] <= pwdata[27:0];
		end
		if (wr_en && sel_mwr && pwdata[cfe_pkg::MSG_STREAM_BIT]) begin
			msg_b_ff[pwdata[cfe_pkg::MSG_IDX_LSB +: IDX_W]] <= pwdata[27:0];
		end
	end

	// read selection
	wire [31:0] status_word = {18'h00000, burst_ff, sat_enable, bi_val, dsat_on_ff, kind_ff};
	wire [31:0] rd_mux =
		sel_ctrl ? {23'h000000, ctrl_ff} :
		sel_rate ? {16'h0000, rate_ff} :
		sel_lvl  ? {20'h00000, level_ff} :
		sel_bur  ? {24'h000000, bursts_ff} :
		sel_bid  ? {24'h000000, bi_delay_ff} :
		sel_fa   ? {4'h0, fill_a_ff} :
		sel_fb   ? {4'h0, fill_b_ff} :
		sel_vm   ? {4'h0, voice_msg_ff} :
		sel_dsat ? {8'h00, dsat_ff} :
		sel_mln  ? {28'h0000000, msg_lines_ff} :
		sel_stat ? status_word : 32'h00000000;

	// read data and error are captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else if (setup_ph) begin
			prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_ff <= !sel_any;
		end
	end

	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;
	assign pready  = 1'b1;

	// sequencer next state: commands first, then segment advance
	always_comb begin
		nxt_kind  = kind_ff;
		nxt_st    = st_ff;
		nxt_left  = adv ? left_ff - 7'h01 : left_ff;
		nxt_rep   = rep_ff;
		nxt_line  = line_ff;
		nxt_burst = burst_ff;
		launch    = 1'b0;
		load_word = 1'b0;
		load_sync = 1'b0;
		if ((halt_ctrl || cmd_fstop) && is_ctrl) begin
			nxt_kind = cfe_pkg::K_NONE;
			launch   = 1'b1;
		end else if (cmd_stop && is_msg) begin
			nxt_kind = stop_kind;
			launch   = 1'b1;
		end else if (cmd_send) begin
			nxt_kind  = send_kind;
			nxt_burst = bursts_ff;
			nxt_line  = '0;
			launch    = 1'b1;
		end else if (cmd_fsend && !chan_voice && kind_ff != cfe_pkg::K_CMSG) begin
			nxt_kind = cfe_pkg::K_FILL;
			launch   = 1'b1;
		end else if (supervisory_pattern_send_cmd && kind_ff == cfe_pkg::K_NONE
				&& chan_voice && narrow) begin
			nxt_kind = cfe_pkg::K_DSAT;
			launch   = 1'b1;
		end else if (supervisory_pattern_stop_cmd && kind_ff == cfe_pkg::K_DSAT) begin
			nxt_kind = cfe_pkg::K_NONE;
			launch   = 1'b1;
		end else if (seg_end) begin
			case (st_ff)
				cfe_pkg::ST_DOT: begin
					nxt_st    = cfe_pkg::ST_SYNC;
					nxt_left  = cfe_pkg::SYNC_LEN;
					load_sync = 1'b1;
				end
				cfe_pkg::ST_SYNC: begin
					nxt_st    = cfe_pkg::ST_WORD;
					nxt_left  = cfe_pkg::WORD_LEN;
					load_word = 1'b1;
				end
				cfe_pkg::ST_WORD: begin
					if (rep_ff + 4'h1 < reps_of(kind_ff)) begin
						nxt_rep = rep_ff + 4'h1;
						if (kind_ff == cfe_pkg::K_WB) begin
							nxt_st   = cfe_pkg::ST_DOT;
							nxt_left = cfe_pkg::DOT_LATER;
						end else begin
							nxt_left  = cfe_pkg::WORD_LEN;
							load_word = 1'b1;
						end
					end else if (kind_ff == cfe_pkg::K_CMSG
							&& {1'b0, line_ff} + 4'h1 < lines_eff) begin
						nxt_line = line_ff + 1'b1;
						launch   = 1'b1;
					end else if (is_msg && mode == cfe_pkg::MODE_CONT) begin
						nxt_line = '0;
						launch   = 1'b1;
					end else if (is_msg && mode == cfe_pkg::MODE_BURST
							&& burst_ff > 8'h01) begin
						nxt_burst = burst_ff - 8'h01;
						nxt_line  = '0;
						launch    = 1'b1;
					end else if (is_msg) begin
						nxt_kind = done_kind;
						launch   = 1'b1;
					end else begin
						launch = 1'b1; // filler and tone repeat
					end
				end
				default: begin
					nxt_st = cfe_pkg::ST_IDLE;
				end
			endcase
		end
		// frame start for the chosen kind
		if (launch) begin
			nxt_rep = 4'h0;
			case (nxt_kind)
				cfe_pkg::K_FILL, cfe_pkg::K_CMSG: begin
					nxt_st   = cfe_pkg::ST_DOT;
					nxt_left = cfe_pkg::DOT_CTRL;
				end
				cfe_pkg::K_WB: begin
					nxt_st   = cfe_pkg::ST_DOT;
					nxt_left = cfe_pkg::DOT_FIRST;
				end
				cfe_pkg::K_NB: begin
					nxt_st    = cfe_pkg::ST_WORD;
					nxt_left  = cfe_pkg::WORD_LEN;
					load_word = 1'b1;
				end
				cfe_pkg::K_DST, cfe_pkg::K_DSAT: begin
					nxt_st    = cfe_pkg::ST_WORD;
					nxt_left  = cfe_pkg::TONE_LEN;
					load_word = 1'b1;
				end
				default: begin
					nxt_st   = cfe_pkg::ST_IDLE;
					nxt_left = 7'h00;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff    <= cfe_pkg::ST_IDLE;
			kind_ff  <= cfe_pkg::K_NONE;
			left_ff  <= 7'h00;
			rep_ff   <= 4'h0;
			line_ff  <= '0;
			burst_ff <= 8'h00;
		end else begin
			st_ff    <= nxt_st;
			kind_ff  <= nxt_kind;
			left_ff  <= nxt_left;
			rep_ff   <= nxt_rep;
			line_ff  <= nxt_line;
			burst_ff <= nxt_burst;
		end
	end

	// shift register and emitted bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_ff        <= 40'h0000000000;
			out_bit_ff   <= 1'b0;
			out_valid_ff <= 1'b0;
		end else begin
			if (load_sync) begin
				sh_ff <= {cfe_pkg::WORD_SYNC, 29'h00000000};
			end else if (load_word) begin
				sh_ff <= load_val;
			end else if (adv) begin
				sh_ff <= {sh_ff[38:0], 1'b0};
			end
			// an ended stream still lets its last bit run a full period
			if (lif.tick) begin
				out_valid_ff <= (kind_ff != cfe_pkg::K_NONE);
				out_bit_ff   <= bi_slot ? bi_val :
					(st_ff == cfe_pkg::ST_DOT) ? dot_bit : sh_ff[39];
			end
		end
	end

	// busy/idle insertion spacing and delayed switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bi_cnt_ff  <= 4'h0;
			bi_trig_ff <= 1'b0;
			bi_dly_ff  <= 8'h00;
			bi_busy_ff <= 1'b0;
		end else if (kind_ff == cfe_pkg::K_NONE || !is_ctrl) begin
			bi_cnt_ff  <= cfe_pkg::BI_SPACING;
			bi_trig_ff <= 1'b0;
			bi_dly_ff  <= 8'h00;
			bi_busy_ff <= 1'b0;
		end else begin
			if (lif.tick) begin
				bi_cnt_ff <= bi_slot ? 4'h0 : bi_cnt_ff + 4'h1;
			end
			if ((sync_delay_option && seg_end && st_ff == cfe_pkg::ST_SYNC)
					|| (first_bit_delay_option && lif.tick)) begin
				bi_trig_ff <= 1'b1;
			end
			if (bi_trig_ff && !bi_busy_ff) begin
				if (bi_dly_ff >= bi_delay_ff) begin
					bi_busy_ff <= 1'b1;
				end else if (lif.tick) begin
					bi_dly_ff <= bi_dly_ff + 8'h01;
				end
			end
		end
	end

	// supervisory pattern enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dsat_on_ff <= 1'b0;
		end else if (supervisory_pattern_send_cmd) begin
			dsat_on_ff <= 1'b1;
		end else if (supervisory_pattern_stop_cmd) begin
			dsat_on_ff <= 1'b0;
		end
	end

	// a stream stays live until its last bit has run out
	wire streaming = (kind_ff != cfe_pkg::K_NONE) || out_valid_ff;

	// line stage hookup
	assign lif.bit_val   = out_bit_ff;
	assign lif.bit_valid = out_valid_ff;
	assign lif.active    = streaming;
	assign lif.invert    = ctrl_ff[cfe_pkg::CTRL_INV_BIT];
	assign lif.level     = level_ff;
	assign lif.rate      = rate_ff;

	cfe_line_out u_line (
		.pclk      (pclk),
		.presetn   (presetn),
		.lif       (lif),
		.mod_level (mod_level)
	);

	// outward levels
	assign output_route_select = ctrl_ff[cfe_pkg::CTRL_ROUTE_BIT];
	assign data_rate           = rate_ff;
	assign sat_enable          = chan_voice && !narrow && (kind_ff != cfe_pkg::K_WB);
	assign tx_active           = streaming;
endmodule : cfe_encoder
`default_nettype wire

//--- rtl/cfe_line_if.sv
// bit stream carrier between framer and line output stage
`timescale 1ns/1ps
`default_nettype none
interface cfe_line_if;
	logic        tick;
	logic        bit_val;
	logic        bit_valid;
	logic        active;
	logic        invert;
	logic [11:0] level;
	logic [15:0] rate;

	modport framer (input tick, output bit_val, bit_valid, active, invert, level, rate);
	modport line   (output tick, input bit_val, bit_valid, active, invert, level, rate);
endinterface : cfe_line_if
`default_nettype wire

//--- rtl/cfe_line_out.sv
// bit-rate divider and bipolar level output stage
`timescale 1ns/1ps
`default_nettype none
module cfe_line_out (
	input  wire logic        pclk,
	input  wire logic        presetn,
	cfe_line_if.line         lif,
	output logic signed [12:0] mod_level
);
	logic [15:0]        div_ff;
	logic [15:0]        reload;
	logic signed [12:0] pos_lvl;
	logic               drive_pos;

	// rate zero behaves as one cycle per bit
	assign reload    = (lif.rate == 16'h0000) ? 16'h0000 : lif.rate - 16'h0001;
	assign lif.tick  = lif.active && (div_ff == 16'h0000);
	assign pos_lvl   = signed'({1'b0, lif.level});
	assign drive_pos = lif.bit_val ^ lif.invert;

	// bit period counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 16'h0000;
		end else if (!lif.active || lif.tick) begin
			div_ff <= lif.active ? reload : 16'h0000;
		end else begin
			div_ff <= div_ff - 16'h0001;
		end
	end

	// level follows bit and polarity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_level <= 13'sh0000;
		end else if (!lif.bit_valid) begin
			mod_level <= 13'sh0000;
		end else begin
			mod_level <= drive_pos ? pos_lvl : -pos_lvl;
		end
	end
endmodule : cfe_line_out
`default_nettype wire

//--- rtl/cfe_pkg.sv
// constants, register map and types of the forward-channel encoder
package cfe_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_RATE      = 8'h04;
	localparam logic [7:0] OFS_LEVEL     = 8'h08;
	localparam logic [7:0] OFS_BURSTS    = 8'h0C;
	localparam logic [7:0] OFS_BI_DELAY  = 8'h10;
	localparam logic [7:0] OFS_FILL_A    = 8'h14;
	localparam logic [7:0] OFS_FILL_B    = 8'h18;
	localparam logic [7:0] OFS_VOICE_MSG = 8'h1C;
	localparam logic [7:0] OFS_DSAT      = 8'h20;
	localparam logic [7:0] OFS_MSG_WR    = 8'h24;
	localparam logic [7:0] OFS_MSG_LINES = 8'h28;
	localparam logic [7:0] OFS_CMD       = 8'h2C;
	localparam logic [7:0] OFS_STATUS    = 8'h30;

	// control register fields
	localparam int CTRL_W           = 9;
	localparam int CTRL_CHAN_BIT    = 0;
	localparam int CTRL_NARROW_BIT  = 1;
	localparam int CTRL_INV_BIT     = 2;
	localparam int CTRL_ROUTE_BIT   = 3;
	localparam int CTRL_MODE_LSB    = 4;
	localparam int CTRL_BI_LSB      = 6;
	localparam int CTRL_PAYLOAD_BIT = 8;

	// command register bits (write-only pulses)
	localparam int CMD_SEND_BIT       = 0;
	localparam int CMD_STOP_BIT       = 1;
	localparam int CMD_FILL_SEND_BIT  = 2;
	localparam int CMD_FILL_STOP_BIT  = 3;
	localparam int CMD_DSAT_SEND_BIT  = 4;
	localparam int CMD_DSAT_STOP_BIT  = 5;

	// message line write fields
	localparam int MSG_STREAM_BIT = 28;
	localparam int MSG_IDX_LSB    = 29;

	// status fields
	localparam int STAT_KIND_LSB  = 0;
	localparam int STAT_DSAT_BIT  = 3;
	localparam int STAT_BI_BIT    = 4;
	localparam int STAT_SAT_BIT   = 5;
	localparam int STAT_BURST_LSB = 6;

	// reset values
	localparam logic [CTRL_W-1:0] RST_CTRL     = 9'h000;
	localparam logic [15:0]       RST_RATE     = 16'h0FA0;
	localparam logic [11:0]       RST_LEVEL    = 12'h400;
	localparam logic [7:0]        RST_BURSTS   = 8'h01;
	localparam logic [7:0]        RST_BI_DELAY = 8'h00;
	localparam logic [23:0]       RST_DSAT     = 24'h2556CB;

	// framing lengths and patterns
	localparam logic [6:0]  DOT_CTRL   = 7'h0A;
	localparam logic [6:0]  DOT_FIRST  = 7'h65;
	localparam logic [6:0]  DOT_LATER  = 7'h25;
	localparam logic [6:0]  SYNC_LEN   = 7'h0B;
	localparam logic [6:0]  WORD_LEN   = 7'h28;
	localparam logic [6:0]  TONE_LEN   = 7'h18;
	localparam logic [3:0]  WB_REPS    = 4'hB;
	localparam logic [3:0]  CTRL_REPS  = 4'hA;
	localparam logic [3:0]  BI_SPACING = 4'hA;
	localparam logic [10:0] WORD_SYNC  = 11'h712;
	localparam logic [11:0] BCH_POLY   = 12'h539;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_BURST  = 2'h1,
		MODE_CONT   = 2'h2
	} cfe_mode_e;

	typedef enum logic [1:0] {
		BI_IDLE      = 2'h0,
		BI_BUSY      = 2'h1,
		BI_SYNC_DLY  = 2'h2,
		BI_FIRST_DLY = 2'h3
	} cfe_bi_e;

	typedef enum logic [2:0] {
		K_NONE = 3'h0,
		K_FILL = 3'h1,
		K_CMSG = 3'h2,
		K_WB   = 3'h3,
		K_NB   = 3'h4,
		K_DST  = 3'h5,
		K_DSAT = 3'h6
	} cfe_kind_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DOT  = 2'b01,
		ST_SYNC = 2'b11,
		ST_WORD = 2'b10
	} cfe_state_e;

endpackage : cfe_pkg

//--- verification/cfe_encoder_sva.sv
// port checks of the forward-channel encoder
`timescale 1ns/1ps
`default_nettype none
module cfe_encoder_sva (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic signed [12:0] mod_level,
	input wire logic               output_route_select,
	input wire logic [15:0]        data_rate,
	input wire logic               tx_active
);
	logic signed [12:0] prev_ff;
	logic [15:0]        run_ff;
	wire logic          acc = psel && penable;
	wire logic          wr = acc && pwrite;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// length of the current output level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= '0;
			run_ff <= '0;
		end else begin
			prev_ff <= mod_level;
			run_ff <= (mod_level != prev_ff) ? 16'h1 : run_ff + 16'h1;
		end
	end
	a_ready_access: assert property (acc |-> pready)
		else $error("pready low in access");
	a_slverr_unmapped: assert property (acc && paddr > cfe_pkg::OFS_STATUS |-> pslverr)
		else $error("unmapped access not refused");
	a_slverr_mapped: assert property (acc && paddr == cfe_pkg::OFS_RATE |-> !pslverr)
		else $error("mapped access refused");
	a_rate_write: assert property ($changed(data_rate) |-> $past(wr && paddr == cfe_pkg::OFS_RATE))
		else $error("rate changed without write");
	a_route_write: assert property ($changed(output_route_select)
		|-> $past(wr && paddr == cfe_pkg::OFS_CTRL))
		else $error("route changed without write");
	a_idle_zero: assert property (!tx_active [*3] |-> mod_level == 0)
		else $error("level driven while idle");
	a_bit_period: assert property (mod_level != prev_ff && prev_ff != 0 && mod_level != 0
		|-> run_ff >= data_rate) else $error("bit shorter than rate");
	a_start_level: assert property ($rose(tx_active) |-> ##[1:3] mod_level != 0)
		else $error("no level after start");
	c_start: cover property ($rose(tx_active));
	c_negative: cover property (mod_level < 0);
	c_refused: cover property (acc && pslverr);
endmodule : cfe_encoder_sva
bind cfe_encoder cfe_encoder_sva u_cfe_encoder_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .mod_level, .output_route_select, .data_rate, .tx_active);
`default_nettype wire

//--- verification/cfe_radio_model.sv
// radio-side model recovering bits from the bipolar level
`timescale 1ns/1ps
`default_nettype none
module cfe_radio_model #(
	parameter int RATE = 4
) (
	input wire logic               pclk,
	input wire logic signed [12:0] mod_level
);
	int   ph;
	logic bits[$];
	// sample mid-bit while the line carries data
	always @(posedge pclk) begin
		if (mod_level == 0) begin
			ph = 0;
		end else begin
			if (ph == RATE / 2) begin
				bits.push_back(mod_level > 0);
			end
			ph = (ph + 1) % RATE;
		end
	end
endmodule : cfe_radio_model
`default_nettype wire

//--- verification/test_cfe_encoder.sv
// self-checking bench for the forward-channel encoder
`timescale 1ns/1ps
`default_nettype none
module test_cfe_encoder;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, route, sat, tx;
	logic signed [12:0] lvl;
	logic [15:0] rate;
	int n_errors = 0, n_tests = 0, cyc = 0;
	cfe_encoder u_cfe_encoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mod_level(lvl), .output_route_select(route),
		.data_rate(rate), .sat_enable(sat), .tx_active(tx));
	cfe_radio_model u_cfe_radio_model (.pclk, .mod_level(lvl));
	always #12.5 pclk = ~pclk;
	// watchdog on the whole run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer, waiting for pready
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	function automatic logic [31:0] pick(int s, int n);
		pick = 0;
		for (int i = 0; i < n; i++) begin
			pick = {pick[30:0], u_cfe_radio_model.bits[s + i]};
		end
	endfunction : pick
	task automatic wait_idle(int lim);
		repeat (3) @(posedge pclk);
		while (tx === 1'b1 && lim > 0) begin
			@(posedge pclk);
			lim--;
		end
		chk("idle", 0, tx);
	endtask : wait_idle
	task automatic s_regs();
		apb(0, cfe_pkg::OFS_RATE, 0);
		chk("rate reset", 32'hFA0, rd);
		apb(0, cfe_pkg::OFS_DSAT, 0);
		chk("pattern reset", 32'h2556CB, rd);
		apb(0, 8'h40, 0);
		chk("unmapped", 1, err);
		apb(1, cfe_pkg::OFS_RATE, 32'h4);
		chk("rate out", 4, rate);
	endtask : s_regs
	task automatic s_wide();
		u_cfe_radio_model.bits.delete();
		apb(1, cfe_pkg::OFS_CTRL, 32'h1);
		apb(1, cfe_pkg::OFS_VOICE_MSG, 32'hA5C3E71);
		apb(1, cfe_pkg::OFS_CMD, 32'h1);
		repeat (20) @(posedge pclk);
		chk("sat", 0, sat);
		wait_idle(6000);
		chk("sat after", 1, sat);
		chk("wide bits", 1032, u_cfe_radio_model.bits.size());
		chk("dotting", 2'b10, pick(0, 2));
		chk("sync", cfe_pkg::WORD_SYNC, pick(189, 11));
		chk("word", 32'hA5C3E71, pick(112, 28));
	endtask : s_wide
	task automatic s_voice();
		logic [31:0] ctl[4] = '{32'h103, 32'h7, 32'h13, 32'h3};
		logic [31:0] e[4] = '{32'hDAA934, 32'h5A3C18E, 32'hA5C3E71, 32'hA5C3E71};
		int n[4] = '{24, 40, 120, 40};
		apb(1, cfe_pkg::OFS_BURSTS, 32'h3);
		for (int k = 0; k < 4; k++) begin
			u_cfe_radio_model.bits.delete();
			apb(1, cfe_pkg::OFS_CTRL, ctl[k]);
			apb(1, cfe_pkg::OFS_CMD, 32'h1);
			wait_idle(2000);
			chk("voice bits", n[k], u_cfe_radio_model.bits.size());
			chk("voice word", e[k], pick(k ? n[k] - 40 : 0, k ? 28 : 24));
		end
		apb(1, cfe_pkg::OFS_CMD, 32'h10);
		apb(1, cfe_pkg::OFS_CMD, 32'h1);
		repeat (300) @(posedge pclk);
		apb(0, cfe_pkg::OFS_STATUS, 0);
		chk("pattern back", 32'hE, rd[3:0]);
		apb(1, cfe_pkg::OFS_CMD, 32'h20);
		wait_idle(20);
		apb(1, cfe_pkg::OFS_CTRL, 32'h23);
		apb(1, cfe_pkg::OFS_CMD, 32'h1);
		repeat (900) @(posedge pclk);
		chk("cont", 1, tx);
		apb(1, cfe_pkg::OFS_CMD, 32'h2);
		wait_idle(200);
	endtask : s_voice
	task automatic s_ctrl();
		for (int k = 0; k < 4; k++) begin
			apb(1, cfe_pkg::OFS_CTRL, 32'(k << 6));
			apb(1, cfe_pkg::OFS_FILL_A, 32'h9D1E0F3);
			apb(1, cfe_pkg::OFS_FILL_B, 32'h62E1F0C);
			u_cfe_radio_model.bits.delete();
			apb(1, cfe_pkg::OFS_CMD, 32'h4);
			repeat (2500) @(posedge pclk);
			chk("filler on", 1, tx);
			chk("frame head", 32'({k != 1, 10'h2AA}), pick(0, 11));
			apb(0, cfe_pkg::OFS_STATUS, 0);
			chk("busy idle", 32'(k == 0), rd[cfe_pkg::STAT_BI_BIT]);
			apb(1, k ? cfe_pkg::OFS_RATE : cfe_pkg::OFS_CMD, k ? 32'h4 : 32'h8);
			wait_idle(20);
		end
		apb(1, cfe_pkg::OFS_MSG_WR, 32'h1234567);
		apb(1, cfe_pkg::OFS_MSG_WR, 32'h11765432);
		apb(1, cfe_pkg::OFS_MSG_LINES, 32'h1);
		apb(1, cfe_pkg::OFS_CMD, 32'h1);
		repeat (2500) @(posedge pclk);
		apb(0, cfe_pkg::OFS_STATUS, 0);
		chk("filler after message", cfe_pkg::K_FILL, rd[2:0]);
		apb(1, cfe_pkg::OFS_CMD, 32'h8);
		wait_idle(20);
	endtask : s_ctrl
	task automatic summarize();
		$display("checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	// reset, then the scenarios in turn
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		s_regs();
		s_wide();
		s_voice();
		s_ctrl();
		summarize();
	end
endmodule : test_cfe_encoder
`default_nettype wire
